// ===== hw/s3u_pkg.sv
package s3u_pkg;
  // pclk rate
  localparam int unsigned PCLK_HZ = 10_000_000;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_OPMODE = 6'h1a;
  localparam logic [5:0] IDX_ERRSTAT = 6'h1b;
  localparam logic [5:0] IDX_FORMAT = 6'h1c;
  localparam logic [5:0] IDX_CONTROL = 6'h1d;
  localparam logic [5:0] IDX_TXDATA = 6'h1e;
  localparam logic [5:0] IDX_RXDATA = 6'h1f;
  localparam logic [5:0] IDX_IRQSTAT = 6'h20;
  localparam logic [5:0] IDX_IRQMASK = 6'h21;
  // field positions
  localparam int unsigned OPM_PORT3_ENABLE = 3;
  localparam int unsigned OPM_OUT_PIN_MODE = 2;
  localparam int unsigned ERR_PARITY = 2;
  localparam int unsigned ERR_FRAMING = 1;
  localparam int unsigned ERR_OVERRUN = 0;
  localparam int unsigned FMT_CHAR_LEN = 1;
  localparam int unsigned FMT_STOP_BITS = 0;
  localparam int unsigned CTL_TX_ENABLE = 3;
  localparam int unsigned CTL_RX_ENABLE = 2;
  localparam int unsigned CTL_RX_ERR_MASK = 1;
  localparam int unsigned IST_RX_DONE = 0;
  localparam int unsigned IST_RX_ERR = 1;
  localparam int unsigned IST_TX_DONE = 2;
  // parity codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  // reset value of the four documented registers
  localparam logic [3:0] REG4_RST = 4'h0;
  // shift clock rates per select code and their divider reloads
  localparam int unsigned SCK0_HZ = 93_750;
  localparam int unsigned SCK1_HZ = 375_000;
  localparam int unsigned SCK2_HZ = 46_875;
  localparam int unsigned SCK3_HZ = 187_500;
  localparam logic [7:0] DIV0 = 8'(PCLK_HZ / SCK0_HZ - 1);
  localparam logic [7:0] DIV1 = 8'(PCLK_HZ / SCK1_HZ - 1);
  localparam logic [7:0] DIV2 = 8'(PCLK_HZ / SCK2_HZ - 1);
  localparam logic [7:0] DIV3 = 8'(PCLK_HZ / SCK3_HZ - 1);
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_START = 3'h1,
    PH_DATA = 3'h3,
    PH_PARITY = 3'h2,
    PH_STOP = 3'h6
  } s3u_phase_e;
  typedef struct packed {
    logic [3:0] opm;
    logic [3:0] fmt;
    logic [3:0] ctl;
    logic [2:0] err;
    logic [2:0] ist;
    logic [2:0] imsk;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic rx_full;
    logic [7:0] div;
    s3u_phase_e tx_ph;
    logic tx_busy;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_par;
    logic line;
    s3u_phase_e rx_ph;
    logic [7:0] rx_tmr;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic rx_par;
    logic rx_perr;
    logic pin;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } s3u_state_s;
  localparam s3u_state_s STATE_RST = '{tx_ph: PH_IDLE, rx_ph: PH_IDLE, line: 1'b1, default: '0};
endpackage : s3u_pkg

// ===== hw/s3u_uart_ctrl.sv
// Local design decision: the APB register port.
`timescale 1ns/10ps
module s3u_uart_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wdt_sp_reset,
  input wire logic ce_reset,
  input wire logic clock_stop,
  input wire logic serial_in,
  input wire logic gp_port_out,
  output logic serial_out_pin,
  output logic irq
);

  s3u_pkg::s3u_state_s q;
  s3u_pkg::s3u_state_s n;
  logic acc;
  logic fire;
  logic wr;
  logic rd;
  logic hit;
  logic [5:0] idx;
  logic [31:0] rdat;
  logic tick;
  logic rx_due;
  logic tx_run;
  logic rx_run;
  logic [3:0] nbits;
  logic [1:0] ps;
  logic [7:0] reload;
  logic ove;
  logic fe;
  logic any_err;
  logic in_page;
  logic aligned;
  logic in_range;
  logic rd_err;
  logic rd_rx;
  logic tx_load;
  logic tx_par_bit;
  logic rx_par_bad;
  logic [2:0] ist_set;
  logic [2:0] err_set;

  function automatic logic [7:0] div_of(input logic [1:0] sel);
    logic [7:0] r;
    unique case (sel)
      2'h0: r = s3u_pkg::DIV0;
      2'h1: r = s3u_pkg::DIV1;
      2'h2: r = s3u_pkg::DIV2;
      2'h3: r = s3u_pkg::DIV3;
    endcase
    return r;
  endfunction : div_of

  always_comb
  begin
    n = q;
    acc = psel & penable & ~q.pready;
    fire = psel & penable & q.pready;
    wr = fire & pwrite;
    rd = fire & ~pwrite;
    idx = paddr[7:2];

    // bus decode
    in_page = (paddr[11:8] == 4'h0);
    aligned = (paddr[1:0] == 2'h0);
    in_range = (idx >= s3u_pkg::IDX_OPMODE) && (idx <= s3u_pkg::IDX_IRQMASK);
    hit = in_page && aligned && in_range;
    rd_err = rd && hit && (idx == s3u_pkg::IDX_ERRSTAT);
    rd_rx = rd && hit && (idx == s3u_pkg::IDX_RXDATA);
    tx_run = q.opm[s3u_pkg::OPM_PORT3_ENABLE] & q.ctl[s3u_pkg::CTL_TX_ENABLE];
    rx_run = q.opm[s3u_pkg::OPM_PORT3_ENABLE] & q.ctl[s3u_pkg::CTL_RX_ENABLE];
    nbits = q.fmt[s3u_pkg::FMT_CHAR_LEN] ? 4'h8 : 4'h7;
    ps = q.fmt[3:2];
    reload = div_of(q.opm[1:0]);
    ove = 1'b0;
    fe = 1'b0;
    any_err = 1'b0;
    tx_load = wr && hit && (idx == s3u_pkg::IDX_TXDATA) && tx_run && !q.tx_busy;
    // sticky event bits: interrupt bits from both engines, error bits from the receiver only
    ist_set = 3'h0;
    err_set = 3'h0;

    // parity bit to send, and parity check of the received bit
    tx_par_bit = 1'b1;
    rx_par_bad = 1'b0;
    unique case (ps)
      s3u_pkg::PAR_ZERO: tx_par_bit = 1'b0;
      s3u_pkg::PAR_ODD:
      begin
        tx_par_bit = ~q.tx_par;
        rx_par_bad = ~(q.rx_par ^ serial_in);
      end
      s3u_pkg::PAR_EVEN:
      begin
        tx_par_bit = q.tx_par;
        rx_par_bad = q.rx_par ^ serial_in;
      end
      s3u_pkg::PAR_NONE: tx_par_bit = 1'b1;
    endcase

    // read data, prepared in the first access cycle
    rdat = 32'h0;
    case (idx)
      s3u_pkg::IDX_OPMODE: rdat = {28'h0, q.opm};
      s3u_pkg::IDX_ERRSTAT: rdat = {29'h0, q.err};
      s3u_pkg::IDX_FORMAT: rdat = {28'h0, q.fmt};
      s3u_pkg::IDX_CONTROL: rdat = {28'h0, q.ctl};
      s3u_pkg::IDX_TXDATA: rdat = {23'h0, q.tx_busy, q.txd};
      s3u_pkg::IDX_RXDATA: rdat = {23'h0, q.rx_full, q.rxd};
      s3u_pkg::IDX_IRQSTAT: rdat = {29'h0, q.ist};
      s3u_pkg::IDX_IRQMASK: rdat = {29'h0, q.imsk};
      default: rdat = 32'h0;
    endcase
    n.pready = acc;
    if (acc)
    begin
      n.prdata = hit ? rdat : 32'h0;
      n.pslverr = ~hit;
    end

    // register writes and read side effects, taken at the completing edge
    if (wr && hit)
    begin
      case (idx)
        s3u_pkg::IDX_OPMODE: n.opm = pwdata[3:0];
        s3u_pkg::IDX_FORMAT: n.fmt = pwdata[3:0];
        s3u_pkg::IDX_CONTROL: n.ctl = {pwdata[3:1], 1'b0};
        s3u_pkg::IDX_TXDATA:
        begin
          if (tx_load)
          begin
            n.txd = pwdata[7:0];
            n.tx_busy = 1'b1;
          end
        end
        s3u_pkg::IDX_IRQSTAT: n.ist = q.ist & ~pwdata[2:0];
        s3u_pkg::IDX_IRQMASK: n.imsk = pwdata[2:0];
        default: n.opm = q.opm;
      endcase
    end
    if (rd_err)
      n.err = 3'h0;
    if (rd_rx)
      n.rx_full = 1'b0;

    // shift clock divider, one-cycle enable per bit
    tick = (q.div == 8'h00);
    n.div = tick ? reload : q.div - 8'h01;

    // transmitter
    if (!tx_run)
    begin
      n.tx_ph = s3u_pkg::PH_IDLE;
      n.tx_busy = 1'b0;
      n.line = 1'b1;
    end
    else if (tick)
    begin
      unique case (q.tx_ph)
        s3u_pkg::PH_IDLE:
        begin
          if (q.tx_busy)
          begin
            n.tx_ph = s3u_pkg::PH_START;
            n.line = 1'b0;
          end
        end
        s3u_pkg::PH_START:
        begin
          n.tx_ph = s3u_pkg::PH_DATA;
          n.line = q.txd[0];
          n.tx_sh = {1'b0, q.txd[7:1]};
          n.tx_par = q.txd[0];
          n.tx_cnt = 4'h1;
        end
        s3u_pkg::PH_DATA:
        begin
          if (q.tx_cnt == nbits)
          begin
            if (ps == s3u_pkg::PAR_NONE)
            begin
              n.tx_ph = s3u_pkg::PH_STOP;
              n.line = 1'b1;
              n.tx_cnt = 4'h0;
            end
            else
            begin
              n.tx_ph = s3u_pkg::PH_PARITY;
              n.line = tx_par_bit;
            end
          end
          else
          begin
            n.line = q.tx_sh[0];
            n.tx_sh = {1'b0, q.tx_sh[7:1]};
            n.tx_par = q.tx_par ^ q.tx_sh[0];
            n.tx_cnt = q.tx_cnt + 4'h1;
          end
        end
        s3u_pkg::PH_PARITY:
        begin
          n.tx_ph = s3u_pkg::PH_STOP;
          n.line = 1'b1;
          n.tx_cnt = 4'h0;
        end
        s3u_pkg::PH_STOP:
        begin
          if (q.tx_cnt == 4'h0 && q.fmt[s3u_pkg::FMT_STOP_BITS])
            n.tx_cnt = 4'h1;
          else
          begin
            n.tx_ph = s3u_pkg::PH_IDLE;
            n.tx_busy = 1'b0;
            ist_set[s3u_pkg::IST_TX_DONE] = 1'b1;
          end
        end
      endcase
    end

    // receiver, sampled at mid-bit
    rx_due = (q.rx_tmr == 8'h00);
    if (!rx_run)
      n.rx_ph = s3u_pkg::PH_IDLE;
    else
    begin
      if (q.rx_ph != s3u_pkg::PH_IDLE)
        n.rx_tmr = rx_due ? reload : q.rx_tmr - 8'h01;
      unique case (q.rx_ph)
        s3u_pkg::PH_IDLE:
        begin
          if (!serial_in)
          begin
            n.rx_ph = s3u_pkg::PH_START;
            n.rx_tmr = {1'b0, reload[7:1]};
          end
        end
        s3u_pkg::PH_START:
        begin
          if (rx_due)
          begin
            n.rx_ph = serial_in ? s3u_pkg::PH_IDLE : s3u_pkg::PH_DATA;
            n.rx_cnt = 4'h0;
            n.rx_par = 1'b0;
            n.rx_perr = 1'b0;
          end
        end
        s3u_pkg::PH_DATA:
        begin
          if (rx_due)
          begin
            n.rx_sh = {serial_in, q.rx_sh[7:1]};
            n.rx_par = q.rx_par ^ serial_in;
            n.rx_cnt = q.rx_cnt + 4'h1;
            if (q.rx_cnt + 4'h1 == nbits)
              n.rx_ph = (ps == s3u_pkg::PAR_NONE) ? s3u_pkg::PH_STOP : s3u_pkg::PH_PARITY;
          end
        end
        s3u_pkg::PH_PARITY:
        begin
          if (rx_due)
          begin
            n.rx_ph = s3u_pkg::PH_STOP;
            n.rx_perr = rx_par_bad;
          end
        end
        s3u_pkg::PH_STOP:
        begin
          if (rx_due)
          begin
            n.rx_ph = s3u_pkg::PH_IDLE;
            fe = ~serial_in;
            ove = q.rx_full & ~rd_rx;
            any_err = fe | ove | q.rx_perr;
            err_set[s3u_pkg::ERR_PARITY] = q.rx_perr;
            err_set[s3u_pkg::ERR_FRAMING] = fe;
            err_set[s3u_pkg::ERR_OVERRUN] = ove;
            n.rxd = q.fmt[s3u_pkg::FMT_CHAR_LEN] ? q.rx_sh : {1'b0, q.rx_sh[7:1]};
            n.rx_full = 1'b1;
            if (!any_err || !q.ctl[s3u_pkg::CTL_RX_ERR_MASK])
              ist_set[s3u_pkg::IST_RX_DONE] = 1'b1;
            if (any_err)
              ist_set[s3u_pkg::IST_RX_ERR] = 1'b1;
          end
        end
      endcase
    end

    // sticky flags: an event in the same cycle as a clear keeps the flag set
    n.err = n.err | err_set;
    n.ist = n.ist | ist_set;

    // system reset sources clear the documented registers
    if (wdt_sp_reset || ce_reset || clock_stop)
    begin
      n.opm = s3u_pkg::REG4_RST;
      n.fmt = s3u_pkg::REG4_RST;
      n.ctl = s3u_pkg::REG4_RST;
      n.err = s3u_pkg::REG4_RST[2:0];
    end

    // output pin and interrupt
    n.pin = q.opm[s3u_pkg::OPM_OUT_PIN_MODE] ? n.line : gp_port_out;
    n.irq = |(n.ist & n.imsk);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= s3u_pkg::STATE_RST;
    else
      q <= n;
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign serial_out_pin = q.pin;
  assign irq = q.irq;

endmodule : s3u_uart_ctrl

// ===== verif/s3u_uart_ctrl_asserts.sv
`timescale 1ns/10ps
module s3u_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wdt_sp_reset,
  input wire logic ce_reset,
  input wire logic clock_stop,
  input wire logic gp_port_out,
  input wire logic serial_out_pin
);
  logic [3:0] opm_q, fmt_q, ctl_q;
  logic wr_go, bad, srst;
  assign wr_go = psel && penable && pready && pwrite && !pslverr;
  assign srst = wdt_sp_reset || ce_reset || clock_stop;
  assign bad = paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0 || paddr[7:2] < 6'h1a || paddr[7:2] > 6'h21;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {opm_q, fmt_q, ctl_q} <= '0;
    else if (srst)
      {opm_q, fmt_q, ctl_q} <= '0;
    else if (wr_go && paddr == 12'h068)
      opm_q <= pwdata[3:0];
    else if (wr_go && paddr == 12'h070)
      fmt_q <= pwdata[3:0];
    else if (wr_go && paddr == 12'h074)
      ctl_q <= {pwdata[3:1], 1'b0};
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence rd_s(a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  pready_resp_a: assert property (acc_s |=> pready) else $error("pready late");
  pready_once_a: assert property (pready |=> !pready) else $error("pready long");
  bad_addr_a: assert property (acc_s ##0 bad |=> pslverr) else $error("no slverr");
  opm_read_a: assert property (rd_s(12'h068) |-> prdata == {28'h0, opm_q})
    else $error("opmode read");
  fmt_read_a: assert property (rd_s(12'h070) |-> prdata == {28'h0, fmt_q})
    else $error("format read");
  ctl_read_a: assert property (rd_s(12'h074) |-> prdata == {28'h0, ctl_q})
    else $error("control read");
  gp_pin_a: assert property (!opm_q[2] |=> serial_out_pin == $past(gp_port_out))
    else $error("port pin");
  idle_pin_a: assert property ((opm_q[2] && !(opm_q[3] && ctl_q[3]))[*2] |=> serial_out_pin)
    else $error("idle pin");
endmodule : s3u_chk
bind s3u_uart_ctrl s3u_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .wdt_sp_reset, .ce_reset, .clock_stop, .gp_port_out, .serial_out_pin);

// ===== verif/s3u_serial_dev.sv
`timescale 1ns/10ps
module s3u_serial_dev (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out
);
  int bitp = 26;
  initial line_out = 1'b1;
  // start bit, cnt bits lsb first, then idle mark
  task automatic send(input logic [11:0] f, input int cnt);
    logic [12:0] v;
    v = {f, 1'b0};
    for (int i = 0; i <= cnt; i++)
    begin
      line_out <= v[i];
      repeat (bitp) @(posedge pclk);
    end
    line_out <= 1'b1;
    @(posedge pclk);
  endtask : send
  task automatic recv(input int cnt, output logic [11:0] f);
    f = '0;
    while (line_in !== 1'b0)
      @(posedge pclk);
    repeat (bitp / 2) @(posedge pclk);
    for (int i = 0; i < cnt; i++)
    begin
      repeat (bitp) @(posedge pclk);
      f[i] = line_in;
    end
  endtask : recv
endmodule : s3u_serial_dev

// ===== verif/test_s3u_uart_ctrl.sv
`timescale 1ns/10ps
module test_s3u_uart_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic wdt_sp_reset, ce_reset, clock_stop, serial_in, gp_port_out, serial_out_pin, irq;
  logic [11:0] paddr, g;
  logic [31:0] pwdata, prdata, d, m;
  logic [15:0] fr;
  logic [3:0] f;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  s3u_uart_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .wdt_sp_reset, .ce_reset, .clock_stop, .serial_in, .gp_port_out, .serial_out_pin, .irq);
  s3u_serial_dev dev (.pclk, .line_in(serial_out_pin), .line_out(serial_in));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic final_report();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] x;
    xfer(a, 1'b1, v, x);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, d);
    chk($sformatf("read %h", a), d, e);
  endtask : rdc
  task automatic waittx();
    do
      xfer(12'h078, 1'b0, 32'h0, d);
    while (d[8] === 1'b1);
  endtask : waittx
  // expected line bits after the start bit, and their count
  function automatic logic [15:0] frame(input logic [7:0] b, input logic [3:0] c);
    logic [11:0] v;
    int n;
    n = c[1] ? 8 : 7;
    v = c[1] ? 12'(b) : 12'(b[6:0]);
    if (c[3:2] != 2'h0)
    begin
      v[n] = (c[3:2] == 2'h3) ? ^v[7:0] : (c[3:2] == 2'h2) ? ~^v[7:0] : 1'b0;
      n++;
    end
    v[n] = 1'b1;
    v[n + 1] = c[0];
    n = n + 1 + int'(c[0]);
    return {4'(n), v};
  endfunction : frame
  initial
  begin
    {presetn, psel, penable, pwrite, wdt_sp_reset, ce_reset, clock_stop, gp_port_out, paddr, pwdata} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    gp_port_out <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++)
      rdc(12'h068 + 12'(4 * i), 32'h0);
    gp_port_out <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("port pin low", 32'(serial_out_pin), 32'h0);
    gp_port_out <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("port pin high", 32'(serial_out_pin), 32'h1);
    xfer(12'h0fc, 1'b0, 32'h0, d);
    wr(12'h068, 32'h4);
    wr(12'h074, 32'hc);
    rdc(12'h074, 32'hc);
    wr(12'h084, 32'h1);
    wr(12'h078, 32'h5a);
    rdc(12'h078, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      case (i)
        0: dev.bitp = int'(s3u_pkg::DIV0) + 1;
        1: dev.bitp = int'(s3u_pkg::DIV1) + 1;
        2: dev.bitp = int'(s3u_pkg::DIV2) + 1;
        default: dev.bitp = int'(s3u_pkg::DIV3) + 1;
      endcase
      m = 32'hc | 32'(i);
      wr(12'h068, m);
      rdc(12'h068, m);
      f = {i[1:0], i[0], i[1]};
      wr(12'h070, 32'(f));
      rdc(12'h070, 32'(f));
      fr = frame(8'ha5, f);
      wr(12'h078, 32'ha5);
      dev.recv(int'(fr[15:12]), g);
      chk("tx frame", 32'(g), 32'(fr[11:0]));
      waittx();
    end
    fr = frame(8'h3c, 4'hf);
    wr(12'h078, 32'ha5);
    fork
      dev.send(fr[11:0], int'(fr[15:12]));
      dev.recv(int'(fr[15:12]), g);
    join
    waittx();
    chk("duplex tx", 32'(g), 32'(12'(frame(8'ha5, 4'hf))));
    rdc(12'h07c, 32'h13c);
    rdc(12'h080, 32'h5);
    chk("irq on", 32'(irq), 32'h1);
    wr(12'h080, 32'h7);
    @(posedge pclk);
    chk("irq off", 32'(irq), 32'h0);
    wr(12'h074, 32'he);
    dev.send(fr[11:0] ^ 12'h100, int'(fr[15:12]));
    rdc(12'h06c, 32'h4);
    rdc(12'h080, 32'h2);
    chk("irq masked", 32'(irq), 32'h0);
    xfer(12'h07c, 1'b0, 32'h0, d);
    repeat (2) dev.send(fr[11:0], int'(fr[15:12]));
    rdc(12'h06c, 32'h1);
    xfer(12'h07c, 1'b0, 32'h0, d);
    dev.send(fr[11:0] & 12'hdff, int'(fr[15:12]));
    rdc(12'h06c, 32'h2);
    for (int k = 0; k < 3; k++)
    begin
      wr(12'h070, 32'h5);
      {clock_stop, ce_reset, wdt_sp_reset} <= 3'(1 << k);
      @(posedge pclk);
      {clock_stop, ce_reset, wdt_sp_reset} <= 3'h0;
      @(posedge pclk);
      rdc(12'h070, 32'h0);
    end
    rdc(12'h068, 32'h0);
    final_report();
  end
endmodule : test_s3u_uart_ctrl
